// File: osp_defines.svh
// Purpose: Named constants for the OTP space and register command block.
// Assumes: One system clock; command codes arrive already decoded into bytes.
// Notes:   Definitions only; included by the package and by every module except osp_host.
`ifndef OSP_DEFINES_SVH
`define OSP_DEFINES_SVH

// ============================================================
// Instruction codes
`define OSP_CMD_WRR 8'h01
`define OSP_CMD_WRDI 8'h04
`define OSP_CMD_RDSR1 8'h05
`define OSP_CMD_WREN 8'h06
`define OSP_CMD_CLRST 8'h30
`define OSP_CMD_RDCR 8'h35
`define OSP_CMD_OTPP 8'h42
`define OSP_CMD_OTPR 8'h4B
`define OSP_CMD_IDRD 8'h9F
`define OSP_CMD_SWRST 8'hF0

// ============================================================
// Register field positions and reset values
`define OSP_STAT_WIP 0
`define OSP_STAT_WEN 1
`define OSP_STAT_EERR 5
`define OSP_STAT_PERR 6
`define OSP_STAT_WMASK 8'h9C
`define OSP_CONF_FREEZE 0
`define OSP_STAT_RST 8'h00
`define OSP_CONF_RST 8'h00

// ============================================================
// OTP space layout
`define OSP_AW 10
`define OSP_BYTES 1024
`define OSP_REGIONS 32
`define OSP_RND_BYTES 16
`define OSP_RND_HI 6'h00
`define OSP_LOCK_BASE 16
`define OSP_ERASED 8'hFF

// ============================================================
// Timing: cycles an OTP byte program keeps the device busy
`define OSP_PROG_LAST 4'h7
`define OSP_CNT_ONE 4'h1
`define OSP_CNT_ZERO 4'h0

// ============================================================
// Identification space contents (values are arbitrary)
`define OSP_ID_MFR 8'h5A
`define OSP_ID_TYPE 8'h3C
`define OSP_ID_CAP 8'h19
`define OSP_ID_FILL 8'h00

`endif

// File: osp_pkg.sv
// Purpose: Shared types for the OTP space and register command block.
// Assumes: osp_defines.svh provides the address width; code, data and state widths are written here.
// Notes:   Types only; numbers live in the defines header.
`default_nettype none
`include "osp_defines.svh"

package osp_pkg;

  // ============================================================
  // Command request and read answer carriers
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [`OSP_AW-1:0] addr;
    logic [15:0] data;
  } osp_cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } osp_rsp_t;

  // ============================================================
  // Controller states
  typedef enum logic [0:0] {
    OSP_IDLE = 1'b0,
    OSP_PROG = 1'b1
  } osp_state_t;

endpackage
`default_nettype wire

// File: osp_id_rom.sv
// Purpose: Read-only identification space.
// Assumes: Address is the full identification read address.
// Notes:   No write port exists, so the host cannot alter it.
`timescale 1ns/1ps
`default_nettype none
`include "osp_defines.svh"

module osp_id_rom (
  // Lookup
  input wire logic [`OSP_AW-1:0] addr,
  output logic [7:0] data
);
  import osp_pkg::*;

  // ============================================================
  // Constant table; unlisted locations read as fill
  always_comb begin
    unique case (addr)
      10'h000: data = `OSP_ID_MFR;
      10'h001: data = `OSP_ID_TYPE;
      10'h002: data = `OSP_ID_CAP;
      default: data = `OSP_ID_FILL;
    endcase
  end

endmodule
`default_nettype wire

// File: osp_otp_array.sv
// Purpose: 1024-byte one-time-program storage with lock bit taps.
// Assumes: Writer has already checked locks, freeze and enable latch.
// Notes:   Storage has no reset: it survives every reset of the device.
`timescale 1ns/1ps
`default_nettype none
`include "osp_defines.svh"

module osp_otp_array (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Factory image load
  input wire logic fac_load,
  input wire logic [127:0] fac_rnd,
  // Program port
  input wire logic we,
  input wire logic [`OSP_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port and lock taps
  input wire logic [`OSP_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [`OSP_REGIONS-1:0] lock_bits
);
  import osp_pkg::*;

  typedef struct packed {
    logic [`OSP_BYTES-1:0][7:0] mem;
  } osp_arr_t;

  osp_arr_t s_r;
  osp_arr_t s_nxt;
  logic [`OSP_BYTES-1:0][7:0] fac_image;

  // ============================================================
  // Shipped image and lock taps, one entry each
  genvar g;
  generate
    for (g = 0; g < `OSP_BYTES; g = g + 1) begin : g_img
      if (g < `OSP_RND_BYTES) begin : g_rnd
        assign fac_image[g] = fac_rnd[8*g +: 8];
      end else begin : g_erased
        assign fac_image[g] = `OSP_ERASED;
      end
    end
    for (g = 0; g < `OSP_REGIONS; g = g + 1) begin : g_lock
      assign lock_bits[g] = s_r.mem[`OSP_LOCK_BASE + g / 8][g % 8];
    end
  endgenerate

  // Programming can only pull bits low
  always_comb begin
    s_nxt = s_r;
    if (fac_load) begin
      s_nxt.mem = fac_image;
    end else if (we) begin
      s_nxt.mem[wr_addr] = s_r.mem[wr_addr] & wr_data;
    end
  end

  // Read is a plain index; the caller registers it
  assign rd_data = s_r.mem[rd_addr];

  // No reset on purpose: contents are non-volatile
  always_ff @(posedge clk) begin
    if (ce) begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// File: osp_otp_space.sv
// Purpose: Command-driven OTP space, identification space and status/config.
// Assumes: A serial front end on CLK hands over one decoded command per cycle.
// Notes:   Answers to reads appear one cycle after the command.
//
// Operation
// - Identification read returns separate ID space
// - Identification space cannot be changed by host
// - 1024-byte OTP, 32 lockable 32-byte regions
// - Factory random number bytes never host programmable
// - Lock bytes hold one bit per region
// - Lock bits ascending; zero means locked
// - Reserved region-0 bytes stay host programmable
// - Regions, lock, reserved bytes ship erased
// - Freeze bit blocks all OTP programming
// - Freeze stays set until next reset
// - Registers reached only by their instruction codes
// - Volatile bits return to defaults on resets
// - Non-volatile and OTP bits survive all resets
// - Locked-region program attempt sets program error
// - Writes refused unless write enable latch set
// - Program error cleared only by clear-status or software reset
`timescale 1ns/1ps
`default_nettype none
`include "osp_defines.svh"

module osp_otp_space (
  // Clock and reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST_N,
  // Factory image load
  input wire logic FACTORY_LOAD,
  input wire logic [127:0] FACTORY_RND,
  // Command request
  input wire osp_pkg::osp_cmd_t CMD,
  // Read answer
  output osp_pkg::osp_rsp_t RSP,
  // Register views
  output logic [7:0] STATUS,
  output logic [7:0] CONFIG,
  output logic BUSY
);
  import osp_pkg::*;

  // ============================================================
  // State of the controller
  typedef struct packed {
    osp_state_t state;
    logic [7:0] stat;
    logic [7:0] conf;
    logic [3:0] cnt;
    logic [`OSP_AW-1:0] paddr;
    logic [7:0] pdata;
    osp_rsp_t rsp;
  } osp_main_t;

  osp_main_t s_r;
  osp_main_t s_nxt;

  logic rst_meta_r;
  logic rst_sync_r;

  logic [7:0] id_data;
  logic [7:0] otp_rd_data;
  logic [`OSP_REGIONS-1:0] lock_bits;
  logic mem_we;
  logic target_locked;
  logic is_cmd;

  // ============================================================
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ============================================================
  // Identification space: lookup only, nothing writes it
  osp_id_rom u_id_rom (
    .addr (CMD.addr),
    .data (id_data)
  );

  // ============================================================
  // OTP storage
  osp_otp_array u_otp (
    .clk (CLK),
    .ce (CE),
    .fac_load (FACTORY_LOAD),
    .fac_rnd (FACTORY_RND),
    .we (mem_we),
    .wr_addr (s_r.paddr),
    .wr_data (s_r.pdata),
    .rd_addr (CMD.addr),
    .rd_data (otp_rd_data),
    .lock_bits (lock_bits)
  );

  // ============================================================
  // Program permission for the requested OTP byte
  // Freeze overrides every lock bit, and the random number is never open.
  always_comb begin
    target_locked = 1'b0;
    if (s_r.conf[`OSP_CONF_FREEZE]) begin
      target_locked = 1'b1;
    end
    // Only the random number is shut; reserved bytes above the locks stay open
    if (CMD.addr[`OSP_AW-1:4] == `OSP_RND_HI) begin
      target_locked = 1'b1;
    end
    if (!lock_bits[CMD.addr[`OSP_AW-1:5]]) begin
      target_locked = 1'b1;
    end
  end

  // A command counts only when the clock enable lets it in
  assign is_cmd = CMD.valid & CE;

  // ============================================================
  // Command decode and programming sequence
  // Lock and reserved bytes are ordinary OTP bytes here, so the reserved
  // bytes stay programmable and region 0's own lock guards them.
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp.valid = 1'b0;
    mem_we = 1'b0;

    // Status reads are served in every state, including while busy
    if (is_cmd && (CMD.code == `OSP_CMD_RDSR1)) begin
      s_nxt.rsp.valid = 1'b1;
      s_nxt.rsp.data = s_r.stat;
    end

    unique case (s_r.state)
      OSP_IDLE: begin
        if (is_cmd) begin
          case (CMD.code)
            `OSP_CMD_IDRD: begin
              s_nxt.rsp.valid = 1'b1;
              s_nxt.rsp.data = id_data;
            end
            `OSP_CMD_RDCR: begin
              s_nxt.rsp.valid = 1'b1;
              s_nxt.rsp.data = s_r.conf;
            end
            `OSP_CMD_OTPR: begin
              s_nxt.rsp.valid = 1'b1;
              s_nxt.rsp.data = otp_rd_data;
            end
            `OSP_CMD_WREN: begin
              s_nxt.stat[`OSP_STAT_WEN] = 1'b1;
            end
            `OSP_CMD_WRDI: begin
              s_nxt.stat[`OSP_STAT_WEN] = 1'b0;
            end
            `OSP_CMD_CLRST: begin
              // Lowers the error flags; the software reset below also clears them
              s_nxt.stat[`OSP_STAT_PERR] = 1'b0;
              s_nxt.stat[`OSP_STAT_EERR] = 1'b0;
            end
            `OSP_CMD_WRR: begin
              if (s_r.stat[`OSP_STAT_WEN]) begin
                s_nxt.stat = (s_r.stat & ~`OSP_STAT_WMASK)
                  | (CMD.data[7:0] & `OSP_STAT_WMASK);
                s_nxt.conf = CMD.data[15:8];
                // Freeze can be set but never lowered by a write
                s_nxt.conf[`OSP_CONF_FREEZE] =
                  s_r.conf[`OSP_CONF_FREEZE] | CMD.data[8];
                s_nxt.stat[`OSP_STAT_WEN] = 1'b0;
              end
            end
            `OSP_CMD_OTPP: begin
              if (s_r.stat[`OSP_STAT_WEN]) begin
                if (target_locked) begin
                  // Failed attempt: latch stays set for the host to clear
                  s_nxt.stat[`OSP_STAT_PERR] = 1'b1;
                end else begin
                  s_nxt.state = OSP_PROG;
                  s_nxt.stat[`OSP_STAT_WIP] = 1'b1;
                  s_nxt.cnt = `OSP_CNT_ZERO;
                  s_nxt.paddr = CMD.addr;
                  s_nxt.pdata = CMD.data[7:0];
                end
              end
            end
            `OSP_CMD_SWRST: begin
              // Volatile bits only; storage keeps its contents
              s_nxt.stat = `OSP_STAT_RST;
              s_nxt.conf = `OSP_CONF_RST;
            end
            default: begin
              // Unknown codes and the status read need nothing more here
            end
          endcase
        end
      end

      OSP_PROG: begin
        // Other commands are dropped while the byte is being written
        if (CE) begin
          s_nxt.cnt = s_r.cnt + `OSP_CNT_ONE;
          if (s_r.cnt == `OSP_PROG_LAST) begin
            mem_we = 1'b1;
            s_nxt.state = OSP_IDLE;
            s_nxt.stat[`OSP_STAT_WIP] = 1'b0;
            s_nxt.stat[`OSP_STAT_WEN] = 1'b0;
          end
        end
      end
    endcase
  end

  // ============================================================
  // Single state register; CE holds everything still
  always_ff @(posedge CLK or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r.state <= OSP_IDLE;
      s_r.stat <= `OSP_STAT_RST;
      s_r.conf <= `OSP_CONF_RST;
      s_r.cnt <= `OSP_CNT_ZERO;
      s_r.paddr <= '0;
      s_r.pdata <= '0;
      s_r.rsp <= '0;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // Outputs straight from the state register
  assign RSP = s_r.rsp;
  assign STATUS = s_r.stat;
  assign CONFIG = s_r.conf;
  assign BUSY = s_r.stat[`OSP_STAT_WIP];

endmodule
`default_nettype wire

// File: osp_otp_space_sva.sv
// Purpose: Port-level checks for the OTP space and register command block.
// Assumes: CE stays high while a program is running.
// Notes:   Bound to every osp_otp_space instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "osp_defines.svh"

module osp_otp_space_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST_N,
  // Command and answers
  input wire osp_pkg::osp_cmd_t CMD,
  input wire osp_pkg::osp_rsp_t RSP,
  input wire logic [7:0] STATUS,
  input wire logic [7:0] CONFIG,
  input wire logic BUSY
);
  import osp_pkg::*;
  // ==========================================================
  // Command taken while idle; during a program all commands except status reads are dropped
  logic tk;
  assign tk = CMD.valid && CE && !BUSY;
  // Commands allowed to lower the program error flag
  logic clr_cmd;
  assign clr_cmd = CMD.valid && CE && CMD.code inside {8'h30, 8'hF0};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========================================================
  // Assertions
  a_read_answer: assert property (tk && CMD.code inside {8'h9F, 8'h35, 8'h4B, 8'h05}
    |=> RSP.valid) else $error("read command gave no answer");
  a_answer_cause: assert property (RSP.valid |-> $past(CMD.valid && CE))
    else $error("answer without command");
  a_id_first: assert property (tk && CMD.code == 8'h9F && CMD.addr == 10'h000
    |=> RSP.data == `OSP_ID_MFR) else $error("identification byte wrong");
  a_wen_gate: assert property (tk && CMD.code == 8'h42 && !STATUS[1]
    |=> !BUSY && STATUS[6] == $past(STATUS[6])) else $error("program ran without latch");
  a_prog_span: assert property ($rose(BUSY) |-> BUSY[*8] ##1 (!BUSY && !STATUS[1]))
    else $error("program busy span wrong");
  a_wren_set: assert property (tk && CMD.code == 8'h06 |=> STATUS[1])
    else $error("write enable not set");
  a_freeze_block: assert property (tk && CMD.code == 8'h42 && STATUS[1] && CONFIG[0]
    |=> STATUS[6] && STATUS[1]) else $error("frozen space accepted program");
  a_freeze_hold: assert property (CONFIG[0] && !(CMD.valid && CE && CMD.code == 8'hF0)
    |=> CONFIG[0]) else $error("freeze dropped");
  a_perr_hold: assert property (STATUS[6] && !clr_cmd |=> STATUS[6])
    else $error("program error dropped");
  a_clear_status: assert property (tk && CMD.code == 8'h30 |=> !STATUS[6])
    else $error("clear status failed");

  // ==========================================================
  // Main scenarios reached
  c_prog: cover property ($rose(BUSY));
  c_frozen: cover property (tk && CMD.code == 8'h42 && CONFIG[0]);
  c_cleared: cover property ($fell(STATUS[6]));
endmodule

bind osp_otp_space osp_otp_space_sva i_osp_otp_space_sva (.CLK(CLK), .CE(CE), .RST_N(RST_N),
  .CMD(CMD), .RSP(RSP), .STATUS(STATUS), .CONFIG(CONFIG), .BUSY(BUSY));
`default_nettype wire

// File: osp_host.sv
// Purpose: Host controller model issuing decoded commands.
// Assumes: One command pulse per call, launched on a falling edge.
// Notes:   Fields are inverted once valid drops, so stale values never match.
`timescale 1ns/1ps
`default_nettype none

module osp_host (
  // Clock
  input wire logic CLK,
  // Command to the device
  output var osp_pkg::osp_cmd_t CMD
);
  import osp_pkg::*;
  // ==========================================================
  // Idle at time zero
  initial begin
    CMD = '0;
  end

  // One command, valid for one cycle only
  task automatic send(input logic [7:0] c, input logic [9:0] a, input logic [15:0] d);
    @(negedge CLK);
    CMD <= {1'b1, c, a, d};
    @(negedge CLK);
    CMD <= {1'b0, ~c, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// File: test_otp_space_protection.sv
// Purpose: Self-checking bench for the OTP space block against a bench model.
// Assumes: Host model drives commands; bench drives the other inputs.
// Notes:   Program time is the designer's fixed eight busy cycles.
`timescale 1ns/1ps
`default_nettype none
`include "osp_defines.svh"

module test_otp_space_protection;
  import osp_pkg::*;
  // ==========================================================
  // Signals and model state
  logic clk, ce, rst_n, fac_load, busy, perr, wen, fz;
  logic [127:0] fac_rnd;
  logic [7:0] status, cfg, srw;
  logic [7:0] mem [1024];
  logic [7:0] codes [9] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h30, 8'h35, 8'h42, 8'h4B, 8'h9F};
  osp_cmd_t cmd;
  osp_rsp_t rsp;
  int n_mismatch, check_count;

  // Clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  osp_otp_space i_osp_otp_space (.CLK(clk), .CE(ce), .RST_N(rst_n), .FACTORY_LOAD(fac_load),
    .FACTORY_RND(fac_rnd), .CMD(cmd), .RSP(rsp), .STATUS(status), .CONFIG(cfg), .BUSY(busy));
  osp_host i_osp_host (.CLK(clk), .CMD(cmd));

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Volatile bits fall back to zero on any reset
  task automatic mreset();
    srw = 8'h00;
    perr = 1'b0;
    wen = 1'b0;
    fz = 1'b0;
  endtask

  function automatic logic [7:0] sr_exp();
    return {srw[7], perr, 1'b0, srw[4:2], wen, 1'b0};
  endfunction

  // ==========================================================
  // One command through the host, model update, then compare
  task automatic cmd_do(input logic [7:0] c, input logic [9:0] a, input logic [15:0] d);
    logic [7:0] e;
    logic rd;
    logic [4:0] r;
    int k;
    e = 8'h00;
    rd = 1'b0;
    r = a[9:5];
    k = 0;
    i_osp_host.send(c, a, d);
    if (ce === 1'b1) begin
      case (c)
        8'h06: wen = 1'b1;
        8'h04: wen = 1'b0;
        8'h30: perr = 1'b0;
        8'hF0: mreset();
        8'h01: if (wen) begin
          srw = d[7:0] & 8'h9C;
          fz = fz | d[8];
          wen = 1'b0;
        end
        8'h05: begin rd = 1'b1; e = sr_exp(); end
        8'h35: begin rd = 1'b1; e = {7'h00, fz}; end
        8'h4B: begin rd = 1'b1; e = mem[a]; end
        8'h9F: begin
          rd = 1'b1;
          e = (a == 0) ? `OSP_ID_MFR : (a == 1) ? `OSP_ID_TYPE :
            (a == 2) ? `OSP_ID_CAP : `OSP_ID_FILL;
        end
        8'h42: if (wen) begin
          // Locked when freeze is set, the target is the random number, or its bit is zero
          if (fz || a < 10'h010 || !mem[16 + r[4:3]][r[2:0]]) perr = 1'b1;
          else begin
            mem[a] = mem[a] & d[7:0];
            wen = 1'b0;
            // Status stays readable while busy, with busy and latch both still up
            i_osp_host.send(8'h05, a, d);
            chk(rsp.valid === 1'b1 && rsp.data === (sr_exp() | 8'h03),
              "status while busy");
            while (busy === 1'b1 && k < 20) begin
              @(negedge clk);
              k++;
            end
            // Two of the eight busy cycles went to the status read
            chk(k == 6 && busy === 1'b0, "program length");
            if (busy !== 1'b0) end_sim();
          end
        end
        default: ;
      endcase
    end
    chk(rsp.valid === rd && (!rd || rsp.data === e), "read answer");
    chk(status === sr_exp() && cfg[0] === fz, "status or config");
  endtask

  task automatic op(input logic [7:0] c);
    cmd_do(c, 10'h000, 16'h0000);
  endtask

  task automatic prog(input logic [9:0] a, input logic [7:0] d);
    op(8'h06);
    cmd_do(8'h42, a, {8'h00, d});
    cmd_do(8'h4B, a, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    void'($urandom(32'h7076fd5e));
    ce = 1'b1;
    rst_n = 1'b0;
    fac_load = 1'b0;
    fac_rnd = {$urandom, $urandom, $urandom, $urandom};
    n_mismatch = 0;
    check_count = 0;
    mreset();
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(status === 8'h00 && cfg === 8'h00 && busy === 1'b0, "reset values");
    fac_load = 1'b1;
    @(negedge clk);
    fac_load = 1'b0;
    for (i = 0; i < 1024; i++) mem[i] = (i < 16) ? fac_rnd[8 * i +: 8] : 8'hFF;
    for (i = 0; i < 48; i++) cmd_do(8'h4B, i[9:0], 16'h0000);
    cmd_do(8'h4B, 10'h3FF, 16'h0000);
    for (i = 0; i < 4; i++) cmd_do(8'h9F, i[9:0], 16'h0000);
    cmd_do(8'h42, 10'h020, 16'h0000);
    prog(10'h005, 8'h00);
    op(8'h30);
    op(8'h04);
    prog(10'h021, 8'h5A);
    prog(10'h021, 8'hFF);
    prog(10'h014, 8'h33);
    prog(10'h010, 8'hFD);
    prog(10'h013, 8'h7F);
    prog(10'h022, 8'h00);
    cmd_do(8'h42, 10'h3FF, 16'h0000);
    op(8'h05);
    op(8'h30);
    for (i = 0; i < 60; i++) begin
      cmd_do(codes[$urandom_range(0, 8)], 10'h020 + 10'($urandom_range(0, 991)),
        {8'h00, 8'($urandom)});
    end
    op(8'h06);
    cmd_do(8'h01, 10'h000, 16'h0100);
    prog(10'h040, 8'h00);
    op(8'h06);
    cmd_do(8'h01, 10'h000, 16'h0000);
    op(8'h35);
    op(8'hF0);
    op(8'h35);
    cmd_do(8'h9F, 10'h000, 16'h0000);
    @(negedge clk);
    ce = 1'b0;
    op(8'h06);
    ce = 1'b1;
    op(8'h06);
    rst_n = 1'b0;
    mreset();
    @(negedge clk);
    chk(status === 8'h00 && cfg === 8'h00, "hardware reset");
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    cmd_do(8'h4B, 10'h021, 16'h0000);
    cmd_do(8'h4B, 10'h010, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
